// ### core/rsl_pkg.sv
// Constants and carrier types for the rail sequence timestamp log.
// Assumes a 25 MHz core clock and comparator levels that are already synchronous.
package rsl_pkg;

   localparam int          RSL_CHANNELS    = 3;
   localparam int          RSL_CLK_NS      = 40;
   localparam int          RSL_TICK_US     = 50;
   localparam int          RSL_TICK_CYCLES = (RSL_TICK_US * 1000) / RSL_CLK_NS;
   localparam logic [10:0] RSL_TICK_LAST   = 11'(RSL_TICK_CYCLES - 1);
   localparam logic [15:0] RSL_TIMER_MAX   = 16'hFFFF;
   localparam logic [15:0] RSL_TIMER_RST   = 16'h0000;
   localparam logic [10:0] RSL_PRESC_RST   = 11'h000;
   localparam logic [7:0]  RSL_RDATA_RST   = 8'h00;

   localparam logic [7:0]  RSL_ADDR_CH1_HIGH = 8'h90;
   localparam logic [7:0]  RSL_ADDR_CH1_LOW  = 8'h91;
   localparam logic [7:0]  RSL_ADDR_CH2_HIGH = 8'h92;
   localparam logic [7:0]  RSL_ADDR_CH2_LOW  = 8'h93;
   localparam logic [7:0]  RSL_ADDR_CH3_HIGH = 8'h94;
   localparam logic [7:0]  RSL_ADDR_CH3_LOW  = 8'h95;

   typedef enum logic [1:0] {
      RSL_IDLE = 2'h0,
      RSL_RISE = 2'h1,
      RSL_FALL = 2'h2
   } rsl_state_e;

   // Sequence request: start pulse, direction and end pulse.
   typedef struct packed {
      logic start;
      logic rising;
      logic done;
   } rsl_seq_s;

   // Register access from the serial register interface.
   typedef struct packed {
      logic       rdEn;
      logic       wrEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } rsl_reg_s;

endpackage : rsl_pkg

// ### core/rsl_timestamp_log.sv
// Timestamp log for channels 1 to 3 of the rail sequence monitor.
// Assumes comparator levels and register strobes synchronous to mclk.
`timescale 1ns/10ps

// Notes on behaviour
// - In power-on or sleep-exit sequences, a rail rising past undervoltage latches the timer.
// - In power-off or sleep-entry sequences, a rail falling below 200mV latches the timer.
// - The sequence timer counts once every 50 microseconds.
// - Each stamp reads as a high byte and a low byte, bits 7 to 0.
// - Stamps are captured only while a power or sleep sequence runs.
// - Stamps sit at 0x91, 0x92, 0x93, 0x94, 0x95; their reset contents are undefined.
// - Channel 1 high byte sits at 0x90, undefined after reset.
module rsl_timestamp_log
   import rsl_pkg::*;
(
   // Clock and reset
   input  wire logic                    mclk,
   input  wire logic                    rstn,
   // Sequence control
   input  wire rsl_seq_s                seq,
   // Comparator levels per channel
   input  wire logic [RSL_CHANNELS-1:0] railAboveUv,
   input  wire logic [RSL_CHANNELS-1:0] railAboveOff,
   // Register access and sequence status
   input  wire rsl_reg_s                regReq,
   output logic [7:0]                   regRdData,
   output logic                         seqActive
);

   rsl_state_e  state;
   rsl_state_e  next_state;
   logic [10:0] presc;
   logic [15:0] timer;
   logic [15:0] stamp [RSL_CHANNELS];
   logic [RSL_CHANNELS-1:0] taken;
   logic [RSL_CHANNELS-1:0] prevUv;
   logic [RSL_CHANNELS-1:0] prevOff;
   logic [RSL_CHANNELS-1:0] capture;
   wire         tickDue = (presc == RSL_TICK_LAST);
   wire         running = (state != RSL_IDLE);
   wire [7:0]   rdMux;

   // A start takes priority over a done in the same cycle, so a back-to-back sequence is kept.
   always_comb begin
      next_state = state;
      case (state)
         RSL_IDLE: begin
            if (seq.start) begin
               next_state = seq.rising ? RSL_RISE : RSL_FALL;
            end
         end
         RSL_RISE, RSL_FALL: begin
            if (seq.start) begin
               next_state = seq.rising ? RSL_RISE : RSL_FALL;
            end else if (seq.done) begin
               next_state = RSL_IDLE;
            end
         end
         default: next_state = RSL_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state <= RSL_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // The timer saturates instead of wrapping so a slow rail never looks early.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         presc <= RSL_PRESC_RST;
         timer <= RSL_TIMER_RST;
      end else if (seq.start) begin
         presc <= RSL_PRESC_RST;
         timer <= RSL_TIMER_RST;
      end else if (running) begin
         presc <= tickDue ? RSL_PRESC_RST : presc + 11'h001;
         if (tickDue && timer != RSL_TIMER_MAX) begin
            timer <= timer + 16'h0001;
         end
      end
   end

   // Edge history runs in every state, so a crossing just after a start is still seen.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         taken   <= '0;
         prevUv  <= '0;
         prevOff <= '0;
      end else begin
         prevUv  <= railAboveUv;
         prevOff <= railAboveOff;
         taken   <= seq.start ? '0 : (taken | capture);
      end
   end

   // Only the first crossing per channel in each sequence is logged; comparator chatter is ignored.
   genvar ch;
   generate
      for (ch = 0; ch < RSL_CHANNELS; ch++) begin : g_chan
         assign capture[ch] = !taken[ch] && !seq.start &&
            ((state == RSL_RISE && railAboveUv[ch] && !prevUv[ch]) ||
             (state == RSL_FALL && !railAboveOff[ch] && prevOff[ch]));

         // Stamps carry no reset; their contents are undefined until the first capture.
         always_ff @(posedge mclk) begin
            if (capture[ch]) begin
               stamp[ch] <= timer;
            end
         end

         a_rise_capture: assert property (@(posedge mclk) disable iff (!rstn)
            (state == RSL_RISE && !seq.start && !taken[ch] && railAboveUv[ch] && !prevUv[ch])
            |=> stamp[ch] == $past(timer))
            else $error("Rising crossing did not latch the timer.");

         a_fall_capture: assert property (@(posedge mclk) disable iff (!rstn)
            (state == RSL_FALL && !seq.start && !taken[ch] && !railAboveOff[ch] && prevOff[ch])
            |=> stamp[ch] == $past(timer))
            else $error("Falling crossing did not latch the timer.");

         a_idle_hold: assert property (@(posedge mclk) disable iff (!rstn)
            (state == RSL_IDLE && !seq.start && taken[ch])[*2] |-> $stable(stamp[ch]))
            else $error("Stamp changed outside a sequence.");

         a_write_ignored: assert property (@(posedge mclk) disable iff (!rstn)
            (regReq.wrEn && !capture[ch] && taken[ch]) |=> $stable(stamp[ch]))
            else $error("Register write altered a stamp.");
      end
   endgenerate

   assign rdMux =
      (regReq.addr == RSL_ADDR_CH1_HIGH) ? stamp[0][15:8] :
      (regReq.addr == RSL_ADDR_CH1_LOW)  ? stamp[0][7:0]  :
      (regReq.addr == RSL_ADDR_CH2_HIGH) ? stamp[1][15:8] :
      (regReq.addr == RSL_ADDR_CH2_LOW)  ? stamp[1][7:0]  :
      (regReq.addr == RSL_ADDR_CH3_HIGH) ? stamp[2][15:8] :
      (regReq.addr == RSL_ADDR_CH3_LOW)  ? stamp[2][7:0]  : RSL_RDATA_RST;

   // Read data holds its last value between reads; writes have no path to the stamps.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         regRdData <= RSL_RDATA_RST;
      end else if (regReq.rdEn) begin
         regRdData <= rdMux;
      end
   end

   assign seqActive = running;

   a_tick_period: assert property (@(posedge mclk) disable iff (!rstn)
      (running && !seq.start && tickDue && timer != RSL_TIMER_MAX) |=> timer == $past(timer) + 16'h0001)
      else $error("Timer did not advance on the tick.");

   a_no_early_tick: assert property (@(posedge mclk) disable iff (!rstn)
      (!tickDue && !seq.start) |=> timer == $past(timer))
      else $error("Timer advanced between ticks.");

   a_start_clears: assert property (@(posedge mclk) disable iff (!rstn)
      seq.start |=> (timer == RSL_TIMER_RST && presc == RSL_PRESC_RST && taken == '0))
      else $error("Sequence start did not clear the timer.");

   a_read_high1: assert property (@(posedge mclk) disable iff (!rstn)
      (regReq.rdEn && regReq.addr == RSL_ADDR_CH1_HIGH && !capture[0])
      |=> regRdData == stamp[0][15:8])
      else $error("Channel 1 high byte read wrong.");

   a_read_low2: assert property (@(posedge mclk) disable iff (!rstn)
      (regReq.rdEn && regReq.addr == RSL_ADDR_CH2_LOW && !capture[1])
      |=> regRdData == stamp[1][7:0])
      else $error("Channel 2 low byte read wrong.");

   a_read_split: assert property (@(posedge mclk) disable iff (!rstn)
      (regReq.rdEn && regReq.addr == RSL_ADDR_CH3_HIGH && !capture[2])
      ##1 (regReq.rdEn && regReq.addr == RSL_ADDR_CH3_LOW && !capture[2])
      |=> {$past(regRdData), regRdData} == stamp[2])
      else $error("Channel 3 bytes do not form the stamp.");

   // Sequence control, capture, timer, prescaler, read-path and reset checks.
   a_seq_enter: assert property (@(posedge mclk) disable iff (!rstn)
      seq.start |=> state == ($past(seq.rising) ? RSL_RISE : RSL_FALL))
      else $error("Sequence start chose the wrong direction.");

   a_done_idle: assert property (@(posedge mclk) disable iff (!rstn)
      (running && seq.done && !seq.start) |=> !running)
      else $error("Sequence end did not return to idle.");

   a_idle_no_capture: assert property (@(posedge mclk) disable iff (!rstn)
      !running |-> capture == '0)
      else $error("Capture fired outside a sequence.");

   a_taken_sticky: assert property (@(posedge mclk) disable iff (!rstn)
      !seq.start |=> (taken & $past(taken)) == $past(taken))
      else $error("Capture flag cleared without a start.");

   a_idle_frozen: assert property (@(posedge mclk) disable iff (!rstn)
      (!running && !seq.start) |=> ($stable(timer) && $stable(presc)))
      else $error("Timer moved while idle.");

   a_presc_range: assert property (@(posedge mclk) disable iff (!rstn)
      presc <= RSL_TICK_LAST)
      else $error("Prescaler passed its last count.");

   a_presc_wrap: assert property (@(posedge mclk) disable iff (!rstn)
      (running && !seq.start && tickDue) |=> presc == RSL_PRESC_RST)
      else $error("Prescaler did not wrap on the tick.");

   a_sat_hold: assert property (@(posedge mclk) disable iff (!rstn)
      (running && !seq.start && timer == RSL_TIMER_MAX) |=> timer == RSL_TIMER_MAX)
      else $error("Timer wrapped past its maximum.");

   a_unmapped_zero: assert property (@(posedge mclk) disable iff (!rstn)
      (regReq.rdEn && (regReq.addr < RSL_ADDR_CH1_HIGH || regReq.addr > RSL_ADDR_CH3_LOW))
      |=> regRdData == RSL_RDATA_RST)
      else $error("Unmapped read returned data.");

   a_read_hold: assert property (@(posedge mclk) disable iff (!rstn)
      !regReq.rdEn |=> $stable(regRdData))
      else $error("Read data changed without a read.");

   a_reset_clear: assert property (@(posedge mclk)
      !rstn |=> (regRdData == RSL_RDATA_RST && state == RSL_IDLE && timer == RSL_TIMER_RST))
      else $error("Reset left state behind.");

endmodule : rsl_timestamp_log

// ### dv/rsl_timestamp_log_bench.sv
// Self-checking bench for the rail sequence timestamp log.
// Assumes rsl_pkg is compiled first; all inputs are driven here.
`timescale 1ns/10ps
module rsl_timestamp_log_bench;
   import rsl_pkg::*;
   logic                    mclk = 1'b0;
   logic                    rstn = 1'b0;
   rsl_seq_s                seq = '0;
   logic [RSL_CHANNELS-1:0] railAboveUv = '0;
   logic [RSL_CHANNELS-1:0] railAboveOff = '0;
   rsl_reg_s                regReq = '0;
   logic [7:0]              regRdData;
   logic                    seqActive;
   int                      fails = 0;
   int                      samples_checked = 0;
   int                      cycles = 0;

   always #20 mclk = ~mclk;

   rsl_timestamp_log rsl_timestamp_log_inst (.mclk(mclk), .rstn(rstn), .seq(seq),
      .railAboveUv(railAboveUv), .railAboveOff(railAboveOff), .regReq(regReq),
      .regRdData(regRdData), .seqActive(seqActive));

   task automatic summarize;
      $display("Checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   // The whole run needs about 8800 cycles, so 40000 means a hang.
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails++;
         summarize();
      end
   end

   task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t read data %h, expected %h", $time, got, exp);
      end
   endtask : cmpByte

   task automatic cmpFlag(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t active flag %b, expected %b", $time, got, exp);
      end
   endtask : cmpFlag

   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] val);
      @(posedge mclk);
      regReq <= '{rdEn: ~wr, wrEn: wr, addr: addr, wrData: val};
      @(posedge mclk);
      regReq <= '0;
      #1;
      if (!wr) cmpByte(regRdData, val);
   endtask : access

   task automatic readPair(input logic [7:0] addr, input logic [15:0] exp);
      @(posedge mclk);
      regReq <= '{rdEn: 1'b1, wrEn: 1'b0, addr: addr, wrData: 8'h00};
      @(posedge mclk);
      regReq <= '{rdEn: 1'b1, wrEn: 1'b0, addr: addr + 8'h01, wrData: 8'h00};
      #1 cmpByte(regRdData, exp[15:8]);
      @(posedge mclk);
      regReq <= '0;
      #1 cmpByte(regRdData, exp[7:0]);
   endtask : readPair

   task automatic control(input logic st, input logic rising);
      @(posedge mclk);
      seq <= '{start: st, rising: rising, done: ~st};
      @(posedge mclk);
      seq <= '0;
      #1 cmpFlag(seqActive, st);
   endtask : control

   initial begin
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      #1 cmpFlag(seqActive, 1'b0);
      control(1'b1, 1'b1);
      repeat (3100) @(posedge mclk);
      railAboveUv[0] <= 1'b1;
      repeat (1250) @(posedge mclk);
      railAboveUv[1] <= 1'b1;
      railAboveUv[0] <= 1'b0;
      @(posedge mclk);
      railAboveUv[0] <= 1'b1;
      control(1'b0, 1'b0);
      access(1'b0, 8'h90, 8'h00);
      access(1'b0, 8'h91, 8'h02);
      access(1'b0, 8'h92, 8'h00);
      access(1'b0, 8'h93, 8'h03);
      access(1'b1, 8'h93, 8'hFF);
      access(1'b1, 8'h91, 8'h5A);
      access(1'b0, 8'h93, 8'h03);
      access(1'b0, 8'h91, 8'h02);
      access(1'b0, 8'h96, 8'h00);
      $display("Rising sequence test finished");
      railAboveOff <= 3'h7;
      control(1'b1, 1'b0);
      repeat (600) @(posedge mclk);
      railAboveOff[0] <= 1'b0;
      railAboveUv[1] <= 1'b0;
      repeat (1250) @(posedge mclk);
      railAboveOff[2] <= 1'b0;
      railAboveUv[1] <= 1'b1;
      control(1'b0, 1'b0);
      railAboveOff[1] <= 1'b0;
      repeat (4) @(posedge mclk);
      access(1'b0, 8'h91, 8'h00);
      access(1'b0, 8'h95, 8'h01);
      access(1'b0, 8'h94, 8'h00);
      readPair(8'h94, 16'h0001);
      access(1'b0, 8'h93, 8'h03);
      $display("Falling sequence test finished");
      control(1'b1, 1'b1);
      repeat (1900) @(posedge mclk);
      control(1'b1, 1'b1);
      repeat (600) @(posedge mclk);
      railAboveUv[2] <= 1'b1;
      control(1'b0, 1'b0);
      access(1'b0, 8'h95, 8'h00);
      $display("Restart test finished");
      summarize();
   end
endmodule : rsl_timestamp_log_bench
